// [rtl/sse_eeprom_dev.sv]
// Serial EEPROM slave: opcode decode, array and status access, page writes
// and the self-timed write cycle. Assumes link pins are asynchronous to pclk.
// Behaviour
// - Everything MSB first; frames start at select fall
// - First byte is opcode, carries ninth address bit
// - Undefined opcode: ignore rest, output floats
// - Deselected: ignore input, output floats
// - Hold low pauses, keeps state, floats output
// - Write-protect low inhibits writes, not running cycle
// - Set-latch opcode needs write-protect high
// - Clear-latch opcode clears latch unless busy
// - Status read opcode shifts out status byte
// - Status write sets protection bits when enabled
// - Array read and write opcodes, bit3 address
// - Status bits: busy, latch; all ones busy
// - Protection codes guard quarter, half, all
// - Protection write runs self-timed busy cycle
// - Latch clears at reset and cycle end
// - Read: opcode, address, then data out
// - Sequential read increments and wraps address
// - Programming starts at select rise after D0
// - Protected addresses are never altered
// - While busy only status read is honoured
// - Eight-byte pages; low three bits wrap
// - Disabled write discarded at select rise
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sse_eeprom_dev #(
    parameter int unsigned WRITE_CYCLES = sse_pkg::TWC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    sse_link_if.device link,
    output logic busy,
    output logic write_enabled,
    output logic [1:0] protect_level
);
    import sse_pkg::*;

    localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] WC_LOAD = CNT_W'(WRITE_CYCLES - 1);

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic sck_prev;
    logic cs_prev;
    wire [4:0] pins_raw = {link.cs_n, link.sck, link.si, link.hold_n, link.wp_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 5'h17;
            sync2 <= 5'h17;
            sck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sck_prev <= sync2[3];
            cs_prev <= sync2[4];
        end
    end

    wire cs_n_s = sync2[4];
    wire sck_s = sync2[3];
    wire si_s = sync2[2];
    wire hold_s = sync2[1];
    wire wp_s = sync2[0];
    wire selected = !cs_n_s;
    wire cs_fall = cs_prev && !cs_n_s;
    wire cs_rise = !cs_prev && cs_n_s;
    // Clock edges count only while selected and not paused
    wire live = selected && hold_s && !cs_fall;
    wire sck_rise = live && sck_s && !sck_prev;
    wire sck_fall = live && !sck_s && sck_prev;

    // ==========================================================
    // Sequencer state
    sse_dev_state_e state;
    logic [2:0] bit_cnt;
    logic [6:0] in_sh;
    logic [7:0] out_sh;
    logic [ADDR_W-1:0] addr;
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask;
    logic [ADDR_W-PAGE_W-1:0] page_base;
    logic [1:0] new_prot;
    logic sr_got;
    logic sr_pend;
    logic aborted;
    logic driving;
    logic so_q;
    logic so_oe_q;
    logic [CNT_W-1:0] wc_cnt;
    logic [7:0] mem [MEM_DEPTH];

    wire [7:0] rx_byte = {in_sh, si_s};
    wire byte_done = sck_rise && (bit_cnt == 3'h7);
    wire op_hi_ok = (rx_byte[7:4] == OP_UPPER);
    wire [2:0] op_lo = rx_byte[2:0];
    wire [7:0] status_byte = busy ? ST_BUSY_VAL : {4'h0, protect_level, write_enabled, 1'b0};
    wire [ADDR_W-1:0] next_addr = addr + 9'h001;
    wire [ADDR_W-1:0] rd_addr = (state == sse_st_raddr) ? {addr[8], rx_byte} : next_addr;
    wire out_state = (state == sse_st_rdata) || (state == sse_st_sr_rd);
    wire wc_done = busy && (wc_cnt == '0);
    // Programming only starts on a clean rise right after a whole byte
    wire data_ready = ((state == sse_st_wdata) && (|page_mask))
        || ((state == sse_st_sr_wr) && sr_got);
    wire wr_go = cs_rise && data_ready && write_enabled && wp_s && !aborted
        && (bit_cnt == 3'h0) && !busy;

    function automatic logic prot_hit(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
        prot_hit = (lvl == PROT_ALL) || ((lvl == PROT_HALF) && a[8])
            || ((lvl == PROT_QUARTER) && (a[8:7] == 2'h3));
    endfunction

    // ==========================================================
    // Byte shifter and opcode decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sse_st_idle;
            bit_cnt <= 3'h0;
            in_sh <= 7'h00;
            out_sh <= 8'h00;
            addr <= 9'h000;
            sr_got <= 1'b0;
            new_prot <= PROT_RESET;
        end else if (!selected || cs_fall) begin
            state <= selected ? sse_st_opcode : sse_st_idle;
            bit_cnt <= 3'h0;
            sr_got <= 1'b0;
        end else begin
            if (sck_rise) begin
                in_sh <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (sck_fall && out_state) begin
                out_sh <= {out_sh[6:0], 1'b0};
            end
            if (byte_done) begin
                case (state)
                    sse_st_opcode: begin
                        addr[8] <= rx_byte[OP_ADDR8_BIT];
                        // Busy hides everything but the status read
                        if (!op_hi_ok || (busy && op_lo != OP_STATUS_READ)) begin
                            state <= sse_st_idle;
                        end else if (op_lo == OP_STATUS_READ) begin
                            state <= sse_st_sr_rd;
                            out_sh <= status_byte;
                        end else if (op_lo == OP_STATUS_WRITE) begin
                            state <= sse_st_sr_wr;
                        end else if (op_lo == OP_ARRAY_READ) begin
                            state <= sse_st_raddr;
                        end else if (op_lo == OP_ARRAY_WRITE) begin
                            state <= sse_st_waddr;
                        end else begin
                            state <= sse_st_idle;
                        end
                    end
                    sse_st_raddr, sse_st_rdata: begin
                        state <= sse_st_rdata;
                        addr <= rd_addr;
                        out_sh <= mem[rd_addr];
                    end
                    sse_st_sr_rd: begin
                        out_sh <= status_byte;
                    end
                    sse_st_waddr: begin
                        state <= sse_st_wdata;
                        addr[7:0] <= rx_byte;
                    end
                    sse_st_wdata: begin
                        addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 3'h1;
                    end
                    sse_st_sr_wr: begin
                        if (!sr_got) begin
                            new_prot <= rx_byte[ST_PROT_HI_BIT:ST_PROT_LO_BIT];
                        end
                        sr_got <= 1'b1;
                    end
                    default: begin
                        state <= sse_st_idle;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Page buffer: later bytes at the same slot overwrite earlier ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_mask <= '0;
            page_base <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= 8'h00;
            end
        end else if (cs_fall && !busy) begin
            page_mask <= '0;
        end else if (byte_done && state == sse_st_wdata) begin
            page_buf[addr[PAGE_W-1:0]] <= rx_byte;
            page_mask[addr[PAGE_W-1:0]] <= 1'b1;
            page_base <= addr[ADDR_W-1:PAGE_W];
        end
    end

    // ==========================================================
    // Output driver: floats when deselected, paused or not sending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driving <= 1'b0;
            so_q <= 1'b1;
            so_oe_q <= 1'b0;
        end else begin
            if (!selected || cs_fall) begin
                driving <= 1'b0;
            end else if (sck_fall && out_state) begin
                driving <= 1'b1;
                so_q <= out_sh[7];
            end
            so_oe_q <= selected && hold_s && out_state && (driving || sck_fall);
        end
    end

    assign link.so = so_q;
    assign link.so_oe = so_oe_q;

    // ==========================================================
    // Write latch, protection bits and the self-timed cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_enabled <= 1'b0;
            protect_level <= PROT_RESET;
            busy <= 1'b0;
            wc_cnt <= '0;
            sr_pend <= 1'b0;
            aborted <= 1'b0;
        end else begin
            if (cs_fall) begin
                aborted <= 1'b0;
            end else if (selected && !wp_s) begin
                aborted <= 1'b1;
            end
            if (byte_done && state == sse_st_opcode && op_hi_ok && !busy) begin
                if (op_lo == OP_SET_WRITE_LATCH && wp_s) begin
                    write_enabled <= 1'b1;
                end else if (op_lo == OP_CLEAR_WRITE_LATCH) begin
                    write_enabled <= 1'b0;
                end
            end
            if (wr_go) begin
                busy <= 1'b1;
                wc_cnt <= WC_LOAD;
                sr_pend <= (state == sse_st_sr_wr);
            end else if (wc_done) begin
                busy <= 1'b0;
                write_enabled <= 1'b0;
                if (sr_pend) begin
                    protect_level <= new_prot;
                end
            end else if (busy) begin
                wc_cnt <= wc_cnt - 1'b1;
            end
        end
    end

    // ==========================================================
    // Array storage, committed at the end of the write cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int j = 0; j < MEM_DEPTH; j++) begin
                mem[j] <= MEM_RESET;
            end
        end else if (wc_done && !sr_pend) begin
            for (int k = 0; k < PAGE_BYTES; k++) begin
                if (page_mask[k] && !prot_hit(protect_level, {page_base, PAGE_W'(k)})) begin
                    mem[{page_base, PAGE_W'(k)}] <= page_buf[k];
                end
            end
        end
    end
endmodule

// [rtl/sse_pkg.sv]
// Constants, register map and state types for the serial EEPROM front end
// and its SPI master. Assumes a single 200 MHz pclk in both ends.
package sse_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned TWC_NS = 5000000;
    localparam int unsigned TWC_CYC = TWC_NS / CLK_NS;
    localparam int unsigned SCK_HALF_NS = 40;
    localparam int unsigned SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
    localparam int unsigned CS_HIGH_NS = 100;
    localparam int unsigned CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // Array geometry
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned MEM_DEPTH = 512;
    localparam int unsigned PAGE_W = 3;
    localparam int unsigned PAGE_BYTES = 8;
    localparam logic [7:0] MEM_RESET = 8'hFF;

    // ==========================================================
    // Operation codes: upper nibble zero, low three bits select
    localparam logic [3:0] OP_UPPER = 4'h0;
    localparam logic [2:0] OP_SET_WRITE_LATCH = 3'h6;
    localparam logic [2:0] OP_CLEAR_WRITE_LATCH = 3'h4;
    localparam logic [2:0] OP_STATUS_READ = 3'h5;
    localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
    localparam logic [2:0] OP_ARRAY_READ = 3'h3;
    localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
    localparam int unsigned OP_ADDR8_BIT = 3;

    // ==========================================================
    // Status byte
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_WEL_BIT = 1;
    localparam int unsigned ST_PROT_LO_BIT = 2;
    localparam int unsigned ST_PROT_HI_BIT = 3;
    localparam logic [7:0] ST_BUSY_VAL = 8'hFF;
    localparam logic [1:0] PROT_RESET = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [1:0] PROT_ALL = 2'h3;

    // ==========================================================
    // Master register map (APB, byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_XFER = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam int unsigned CTRL_WP_BIT = 0;
    localparam int unsigned CTRL_HOLD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int unsigned XFER_LAST_BIT = 8;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_OPEN_BIT = 1;
    localparam int unsigned STAT_RX_LSB = 8;

    typedef enum logic [2:0] {
        sse_st_idle, sse_st_opcode, sse_st_raddr, sse_st_waddr,
        sse_st_rdata, sse_st_wdata, sse_st_sr_rd, sse_st_sr_wr
    } sse_dev_state_e;

    typedef enum logic [2:0] {
        sse_h_idle, sse_h_lead, sse_h_low, sse_h_high, sse_h_wait, sse_h_tail, sse_h_gap
    } sse_host_state_e;
endpackage

// [rtl/sse_link_if.sv]
// Serial link between the EEPROM front end and its SPI master.
// The output is resolved here: an undriven data-out line reads high.
`timescale 1ns/1ps
interface sse_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe;
    wire so_line = so_oe ? so : 1'b1;

    modport device (input cs_n, input sck, input si, input hold_n, input wp_n,
                    output so, output so_oe);
    modport host (output cs_n, output sck, output si, output hold_n, output wp_n,
                  input so_line);
endinterface

// [rtl/sse_spi_host.sv]
// SPI master for the EEPROM link, driven by software over APB.
// Assumes pclk at 200 MHz; the serial clock is divided down from it.
`timescale 1ns/1ps
module sse_spi_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sse_link_if.host link
);
    import sse_pkg::*;

    // ==========================================================
    // APB slave, one wait-free access phase
    logic [1:0] ctrl;
    logic so_m;
    logic so_s;
    sse_host_state_e hstate;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic last;
    logic [2:0] bit_cnt;
    logic [7:0] tmr;
    logic cs_q;
    logic sck_q;
    logic si_q;
    logic hold_q;
    logic wp_q;

    wire setup = psel && !penable;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_xfer = (paddr == REG_XFER);
    wire hit_stat = (paddr == REG_STAT);
    wire mapped = hit_ctrl || hit_xfer || hit_stat;
    wire wr_en = psel && penable && pready && pwrite;
    wire eng_busy = (hstate != sse_h_idle) && (hstate != sse_h_wait);
    wire start = wr_en && hit_xfer && !eng_busy;
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl}
        : hit_stat ? {16'h0, rx_byte, 6'h0, !cs_q, eng_busy} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            ctrl <= CTRL_RESET;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup ? rd_mux : prdata;
            if (wr_en && hit_ctrl) begin
                ctrl <= pwdata[1:0];
            end
        end
    end

    // ==========================================================
    // Byte engine, SPI mode 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_m <= 1'b1;
            so_s <= 1'b1;
        end else begin
            so_m <= link.so_line;
            so_s <= so_m;
        end
    end

    wire tmr_done = (tmr == 8'h00);
    // A pause freezes the engine only while the clock sits low
    wire paused = (hstate == sse_h_low) && !hold_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate <= sse_h_idle;
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            rx_byte <= 8'h00;
            last <= 1'b0;
            bit_cnt <= 3'h0;
            tmr <= 8'h00;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
        end else if (start) begin
            tx_sh <= pwdata[7:0];
            last <= pwdata[XFER_LAST_BIT];
            bit_cnt <= 3'h0;
            cs_q <= 1'b0;
            si_q <= pwdata[7];
            tmr <= 8'(SCK_HALF_CYC - 1);
            hstate <= cs_q ? sse_h_lead : sse_h_low;
        end else if (!paused) begin
            if (!tmr_done) begin
                tmr <= tmr - 8'h01;
            end else begin
                case (hstate)
                    sse_h_lead: begin
                        hstate <= sse_h_low;
                        tmr <= 8'(SCK_HALF_CYC - 1);
                    end
                    sse_h_low: begin
                        sck_q <= 1'b1;
                        rx_sh <= {rx_sh[6:0], so_s};
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        hstate <= sse_h_high;
                        tmr <= 8'(SCK_HALF_CYC - 1);
                    end
                    sse_h_high: begin
                        sck_q <= 1'b0;
                        si_q <= tx_sh[7];
                        bit_cnt <= bit_cnt + 3'h1;
                        tmr <= 8'(SCK_HALF_CYC - 1);
                        if (bit_cnt == 3'h7) begin
                            rx_byte <= rx_sh;
                            hstate <= last ? sse_h_tail : sse_h_wait;
                        end else begin
                            hstate <= sse_h_low;
                        end
                    end
                    sse_h_tail: begin
                        // Select rises in the clock-low time right after the last bit
                        cs_q <= 1'b1;
                        hstate <= sse_h_gap;
                        tmr <= 8'(CS_HIGH_CYC - 1);
                    end
                    sse_h_gap: begin
                        hstate <= sse_h_idle;
                    end
                    sse_h_wait, sse_h_idle: begin
                        hstate <= hstate;
                    end
                    default: begin
                        hstate <= sse_h_idle;
                    end
                endcase
            end
        end
    end

    // Hold and write protect follow software; hold moves only with the clock low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b1;
            wp_q <= 1'b1;
        end else begin
            wp_q <= ctrl[CTRL_WP_BIT];
            if (!sck_q) begin
                hold_q <= ctrl[CTRL_HOLD_BIT];
            end
        end
    end

    assign link.cs_n = cs_q;
    assign link.sck = sck_q;
    assign link.si = si_q;
    assign link.hold_n = hold_q;
    assign link.wp_n = wp_q;
endmodule

// [bench/sse_link_asserts.sv]
// Concurrent checks on the serial link and the device status outputs.
// Assumes link pins are seen from the pclk domain of both ends.
`timescale 1ns/1ps
module sse_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic write_enabled,
    input wire logic [1:0] protect_level
);
    // ==========================================================
    // Properties; six cycles covers the pin synchronisers
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence deselected_s; cs_n [*6]; endsequence
    sequence paused_s; !hold_n [*6]; endsequence
    sequence cycle_start_s; $rose(busy); endsequence
    sel_float_a: assert property (deselected_s |-> !so_oe)
        else $error("data out driven while deselected");
    hold_float_a: assert property (paused_s |-> !so_oe)
        else $error("data out driven while paused");
    so_edge_a: assert property (so_oe && $changed(so) |-> !sck)
        else $error("data out changed during clock high");
    start_rise_a: assert property (cycle_start_s |-> cs_n)
        else $error("write cycle started with select low");
    busy_len_a: assert property (cycle_start_s |=> busy [*8])
        else $error("write cycle too short");
    latch_end_a: assert property ($fell(busy) |-> !write_enabled)
        else $error("latch survived write cycle");
    latch_set_a: assert property ($rose(write_enabled) |-> !cs_n && wp_n)
        else $error("latch set outside frame or protected");
    prot_commit_a: assert property ($changed(protect_level) |-> $fell(busy))
        else $error("protection changed outside write cycle");
endmodule

// [bench/testbench.sv]
// Self-checking bench: APB drives the SPI master, which talks to the
// EEPROM front end through the link interface. One 200 MHz pclk.
`timescale 1ns/1ps
module testbench;
    import sse_pkg::*;
    // ==========================================================
    // Opcodes, ninth address bit set on array access
    localparam logic [7:0] SET_B = {OP_UPPER, 1'b0, OP_SET_WRITE_LATCH};
    localparam logic [7:0] CLR_B = {OP_UPPER, 1'b0, OP_CLEAR_WRITE_LATCH};
    localparam logic [7:0] SRD_B = {OP_UPPER, 1'b0, OP_STATUS_READ};
    localparam logic [7:0] SWR_B = {OP_UPPER, 1'b0, OP_STATUS_WRITE};
    localparam logic [7:0] RD_B = {OP_UPPER, 1'b1, OP_ARRAY_READ};
    localparam logic [7:0] WR_B = {OP_UPPER, 1'b1, OP_ARRAY_WRITE};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic dev_busy, dev_wel;
    logic [1:0] dev_prot;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rxq[$];
    logic [7:0] q[$];
    int num_errors, n_checks;
    sse_link_if link ();
    // Long enough that a status frame still lands inside the cycle
    sse_eeprom_dev #(.WRITE_CYCLES(2000)) u_sse_eeprom_dev (.pclk(pclk), .presetn(presetn),
        .link(link), .busy(dev_busy), .write_enabled(dev_wel), .protect_level(dev_prot));
    sse_spi_host u_sse_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    sse_link_asserts u_sse_link_asserts (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
        .sck(link.sck), .hold_n(link.hold_n), .wp_n(link.wp_n), .so(link.so),
        .so_oe(link.so_oe), .busy(dev_busy), .write_enabled(dev_wel),
        .protect_level(dev_prot));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(pready, 1'b1);
        if (pready !== 1'b1)
            print_verdict();
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] b[$]);
        rxq = {};
        foreach (b[i]) begin
            apb(1'b1, REG_XFER, {23'h0, i == b.size() - 1, b[i]});
            rd = 32'h1;
            for (int k = 0; k < 200 && rd[STAT_BUSY_BIT] !== 1'b0; k++)
                apb(1'b0, REG_STAT, 32'h0);
            chk(rd[STAT_BUSY_BIT], 1'b0);
            if (rd[STAT_BUSY_BIT] !== 1'b0)
                print_verdict();
            rxq.push_back(rd[STAT_RX_LSB +: 8]);
        end
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 3000 && dev_busy !== 1'b0; k++)
            @(posedge pclk);
        chk(dev_busy, 1'b0);
        if (dev_busy !== 1'b0)
            print_verdict();
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        frame('{SRD_B, 8'h00});
        chk(rxq[1], 8'h00);
        chk(dev_wel, 1'b0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(perr, 1'b1);
        $display("t_reset done");
    endtask
    task automatic t_latch();
        frame('{SET_B});
        chk(dev_wel, 1'b1);
        frame('{SRD_B, 8'h00});
        chk(rxq[1], 8'h02);
        frame('{CLR_B});
        chk(dev_wel, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (8) @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h2);
        frame('{SET_B});
        chk(dev_wel, 1'b0);
        apb(1'b1, REG_CTRL, 32'h3);
        $display("t_latch done");
    endtask
    task automatic t_page();
        frame('{SET_B});
        q = '{WR_B, 8'hFE};
        for (int i = 0; i < 9; i++)
            q.push_back(8'h10 + 8'(i));
        frame(q);
        chk(dev_busy, 1'b1);
        frame('{SRD_B, 8'h00});
        chk(rxq[1], ST_BUSY_VAL);
        // The latch stays set until the cycle ends, so an honoured clear would show
        frame('{CLR_B});
        chk(dev_wel, 1'b1);
        wait_idle();
        chk(dev_wel, 1'b0);
        frame('{RD_B, 8'hFE, 8'h00, 8'h00, 8'h00});
        chk(rxq[2], 8'h18);
        chk(rxq[3], 8'h11);
        chk(rxq[4], MEM_RESET);
        $display("t_page done");
    endtask
    task automatic t_prot();
        frame('{SET_B});
        frame('{SWR_B, {4'h0, PROT_QUARTER, 2'b00}});
        wait_idle();
        chk(dev_prot, PROT_QUARTER);
        frame('{SRD_B, 8'h00});
        chk(rxq[1], {4'h0, PROT_QUARTER, 2'b00});
        frame('{SET_B});
        frame('{WR_B, 8'h80, 8'h5A});
        wait_idle();
        frame('{RD_B, 8'h80, 8'h00});
        chk(rxq[2], MEM_RESET);
        $display("t_prot done");
    endtask
    task automatic t_invalid();
        // The released data-out line reads high
        frame('{8'h07, 8'h00});
        chk(rxq[1], 8'hFF);
        $display("t_invalid done");
    endtask
    task automatic t_hold();
        // Pause after the opcode with data out driven, then finish the status read
        apb(1'b1, REG_XFER, {24'h0, SRD_B});
        repeat (200) @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (8) @(posedge pclk);
        chk(link.so_oe, 1'b0);
        apb(1'b1, REG_CTRL, 32'h3);
        frame('{8'h00});
        chk(rxq[0], {4'h0, PROT_QUARTER, 2'b00});
        $display("t_hold done");
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, perr} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_latch();
        t_page();
        t_prot();
        t_invalid();
        t_hold();
        print_verdict();
    end
endmodule
